// ---- src/tpc_pin_ctrl.sv ----
// transceiver pin control: regulator/fallback, wake, rxd, shared sdo
//
// Function
// - regulator enable on in all modes but sleep; sleep leaves it floating
// - enable-control bit 6 set disables the regulator enable function
// - enable-control bit 5 set turns the pin into the fallback output
// - watchdog timeout turns the fallback output on
// - three good triggers release fallback, or one when bits 3:2 are 01
// - fail-safe entry turns fallback on when both features enabled
// - writing 1 to enable-control bit 1 turns fallback off
// - local wake on either edge by default
// - wake config selects rise, fall, pulse width or filtered edge
// - wake holds rxd low, or pulses it when rxd_wake_style set
// - after power-up rxd is low since device sits in standby
// - shared pin is serial output only unless sdo_role_select set
// - with role set and select high, pin is low on interrupt except in sleep, where it floats
// - while select is low, pin carries serial output data
// - interrupt is OR of all unmasked flags in 0x51 to 0x54
// - registers accessed only while select low and clock toggling
// - txd low is dominant in normal mode only, high recessive and idle
// - mode register selects operating mode; fail-safe events enter fail-safe when fs_cfg_q bit 0 set
`timescale 1ns/1ns
module tpc_pin_ctrl (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // spi
  input wire logic sclk_in,
  input wire logic spi_select_low_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // can side
  input wire logic txd_in,
  input wire logic can_rx_in,
  output logic rxd_out,
  output logic can_dominant_out,
  // wake pin
  input wire logic wake_pin_in,
  // regulator enable / fallback pin
  output logic regulator_enable_out,
  output logic regulator_enable_oe_out,
  // watchdog and faults
  input wire logic wd_timeout_in,
  input wire logic wd_good_trigger_in,
  input wire logic wd_bad_trigger_in,
  input wire logic failsafe_event_in,
  input wire logic [8*tpc_pkg::NUM_FLAG_REGS-1:0] fault_set_in
);
  import tpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic spi_bit;
  logic wr;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wake_evt;
  logic [7:0] wake_cfg_q;
  logic [7:0] rxd_cfg_q;
  logic [7:0] fs_cfg_q;
  logic [7:0] en_ctrl_q;
  logic [7:0] sdo_cfg_q;
  logic [7:0] flags_q [NUM_FLAG_REGS];
  logic [7:0] masks_q [NUM_FLAG_REGS];
  logic [NUM_FLAG_REGS-1:0] reg_irq;
  logic irq_any;
  tpc_mode_e mode_q;
  tpc_mode_e mode_d;
  logic limp_on_q;
  logic [1:0] trig_cnt_q;
  logic [1:0] trig_need;
  logic limp_set;
  logic limp_clr;
  logic [7:0] rxd_pulse_q;
  logic fb_sel;
  logic fs_en;
  logic wr_mode;
  logic wr_en;
  logic [2:0] mode_code;

  assign fb_sel = en_ctrl_q[FB_SEL_BIT];
  assign fs_en = fs_cfg_q[FS_EN_BIT];
  assign wr_mode = wr && addr == ADDR_MODE;
  assign wr_en = wr && addr == ADDR_EN_CTRL;

  ////////////////////////////////////////////////////////////////////////////
  // sub blocks
  tpc_spi_slave u_spi (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .sclk_in(sclk_in),
    .spi_select_low_in(spi_select_low_in),
    .sdi_in(sdi_in),
    .rdata_in(rdata),
    .sdo_out(spi_bit),
    .wr_out(wr),
    .addr_out(addr),
    .wdata_out(wdata)
  );

  tpc_wake_det u_wake (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .wake_pin_in(wake_pin_in),
    .cfg_in(wake_cfg_q),
    .arm_in(mode_q == TPC_STANDBY || mode_q == TPC_SLEEP),
    .wake_out(wake_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_cfg_q <= CFG_RST;
      rxd_cfg_q <= CFG_RST;
      fs_cfg_q <= CFG_RST;
      en_ctrl_q <= CFG_RST;
      sdo_cfg_q <= CFG_RST;
    end else if (wr) begin
      if (addr == ADDR_WAKE_CFG) begin
        wake_cfg_q <= wdata;
      end else if (addr == ADDR_RXD_CFG) begin
        rxd_cfg_q <= wdata;
      end else if (addr == ADDR_FS_CFG) begin
        fs_cfg_q <= wdata;
      end else if (addr == ADDR_EN_CTRL) begin
        en_ctrl_q <= {wdata[7:2], 1'b0, wdata[0]};
      end else if (addr == ADDR_SDO_CFG) begin
        sdo_cfg_q <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault flags and masks
  for (genvar i = 0; i < NUM_FLAG_REGS; i++) begin : g_flag
    logic [7:0] set;
    logic [7:0] clr;
    assign set = fault_set_in[8*i +: 8] |
      ((i == 0 && wake_evt) ? 8'h80 : 8'h00);
    assign clr = (wr && addr == ADDR_FLAG0 + 7'(i)) ? wdata : 8'h00;
    assign reg_irq[i] = |(flags_q[i] & ~masks_q[i]);
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        flags_q[i] <= (i == 0) ? FLAG0_RST : CFG_RST;
        masks_q[i] <= CFG_RST;
      end else begin
        flags_q[i] <= (flags_q[i] & ~clr) | set;
        if (wr && addr == ADDR_MASK0 + 7'(i)) begin
          masks_q[i] <= wdata;
        end
      end
    end
  end
  assign irq_any = |reg_irq;

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    case (mode_q)
      TPC_NORMAL: mode_code = MODE_NORMAL;
      TPC_LISTEN: mode_code = MODE_LISTEN;
      TPC_SLEEP: mode_code = MODE_SLEEP;
      TPC_FAILSAFE: mode_code = MODE_FAILSAFE;
      default: mode_code = MODE_STANDBY;
    endcase
    if (addr == ADDR_MODE) begin
      rdata = {5'h00, mode_code};
    end else if (addr == ADDR_WAKE_CFG) begin
      rdata = wake_cfg_q;
    end else if (addr == ADDR_RXD_CFG) begin
      rdata = rxd_cfg_q;
    end else if (addr == ADDR_FS_CFG) begin
      rdata = fs_cfg_q;
    end else if (addr == ADDR_EN_CTRL) begin
      rdata = en_ctrl_q;
    end else if (addr == ADDR_SDO_CFG) begin
      rdata = sdo_cfg_q;
    end else if (addr == ADDR_GLOBAL) begin
      rdata = {4'h0, reg_irq};
    end else if (addr >= ADDR_FLAG0 && addr < ADDR_FLAG0 + 7'h04) begin
      rdata = flags_q[2'(addr - ADDR_FLAG0)];
    end else if (addr >= ADDR_MASK0 && addr < ADDR_MASK0 + 7'h04) begin
      rdata = masks_q[2'(addr - ADDR_MASK0)];
    end else begin
      rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating mode
  always_comb begin
    mode_d = mode_q;
    if (failsafe_event_in && fs_en) begin
      mode_d = TPC_FAILSAFE;
    end else if (wr_mode) begin
      case (wdata[2:0])
        MODE_NORMAL: mode_d = TPC_NORMAL;
        MODE_LISTEN: mode_d = TPC_LISTEN;
        MODE_STANDBY: mode_d = TPC_STANDBY;
        MODE_SLEEP: mode_d = TPC_SLEEP;
        default: mode_d = mode_q;
      endcase
    end else if (mode_q == TPC_SLEEP && wake_evt) begin
      mode_d = TPC_STANDBY;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= TPC_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fallback output
  assign trig_need = (en_ctrl_q[TRIG_SEL_LSB +: 2] == TRIG_SEL_ONE) ?
    TRIGS_ONE : TRIGS_DEFAULT;
  assign limp_set = fb_sel && (wd_timeout_in || (fs_en &&
    mode_d == TPC_FAILSAFE && mode_q != TPC_FAILSAFE));
  assign limp_clr = (wr_en && wdata[FB_RST_BIT]) ||
    (limp_on_q && wd_good_trigger_in && trig_cnt_q + 2'h1 >= trig_need);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      limp_on_q <= 1'b0;
      trig_cnt_q <= 2'h0;
    end else begin
      limp_on_q <= limp_set | (limp_on_q & ~limp_clr);
      if (!limp_on_q || wd_bad_trigger_in || limp_clr) begin
        trig_cnt_q <= 2'h0;
      end else if (wd_good_trigger_in) begin
        trig_cnt_q <= trig_cnt_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      regulator_enable_out <= 1'b0;
      regulator_enable_oe_out <= 1'b0;
    end else if (fb_sel) begin
      regulator_enable_out <= limp_on_q;
      regulator_enable_oe_out <= limp_on_q;
    end else begin
      regulator_enable_out <= !en_ctrl_q[EN_DIS_BIT] &&
        mode_q != TPC_SLEEP;
      regulator_enable_oe_out <= !en_ctrl_q[EN_DIS_BIT] &&
        mode_q != TPC_SLEEP;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rxd_pulse_q <= 8'h00;
      rxd_out <= 1'b0;
    end else begin
      if (wake_evt && rxd_cfg_q[RXD_STYLE_BIT]) begin
        rxd_pulse_q <= 8'(RXD_PULSE_CYC);
      end else if (rxd_pulse_q != 8'h00) begin
        rxd_pulse_q <= rxd_pulse_q - 8'h01;
      end
      case (mode_q)
        TPC_NORMAL, TPC_LISTEN: rxd_out <= can_rx_in;
        TPC_SLEEP: rxd_out <= 1'b1;
        default: begin
          if (rxd_cfg_q[RXD_STYLE_BIT]) begin
            rxd_out <= rxd_pulse_q == 8'h00 &&
              !flags_q[0][FLAG_PWRON_BIT];
          end else begin
            rxd_out <= !flags_q[0][FLAG_WAKE_BIT] &&
              !flags_q[0][FLAG_PWRON_BIT];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      can_dominant_out <= 1'b0;
    end else begin
      can_dominant_out <= mode_q == TPC_NORMAL && !txd_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else if (!spi_select_low_in) begin
      sdo_out <= spi_bit;
      sdo_oe_out <= 1'b1;
    end else if (sdo_cfg_q[SDO_ROLE_BIT] && mode_q != TPC_SLEEP) begin
      sdo_out <= !irq_any;
      sdo_oe_out <= 1'b1;
    end else begin
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  inh_sleep_off_a: assert property (!fb_sel && mode_q == TPC_SLEEP
    |=> !regulator_enable_oe_out) else $error("enable on in sleep");
  inh_disable_a: assert property (!fb_sel && en_ctrl_q[EN_DIS_BIT]
    |=> !regulator_enable_oe_out) else $error("enable not off");
  fb_pin_a: assert property (fb_sel |=> regulator_enable_out ==
    $past(limp_on_q)) else $error("pin not fallback");
  fb_timeout_a: assert property (fb_sel && wd_timeout_in |=> limp_on_q)
    else $error("timeout did not set fallback");
  fb_one_trig_a: assert property (limp_on_q && wd_good_trigger_in &&
    trig_need == TRIGS_ONE && !limp_set |=> !limp_on_q)
    else $error("single trigger did not release");
  fb_three_trig_a: assert property (limp_on_q && trig_cnt_q == 2'h0 &&
    trig_need == TRIGS_DEFAULT && !limp_set && !wr_en |=> limp_on_q)
    else $error("released before three triggers");
  fb_failsafe_a: assert property ($rose(mode_q == TPC_FAILSAFE) &&
    $past(fb_sel) |-> limp_on_q) else $error("fallback off in fs");
  fb_reset_a: assert property (wr_en && wdata[FB_RST_BIT] && !limp_set
    |=> !limp_on_q) else $error("fallback reset ignored");
  rxd_hold_a: assert property (mode_q == TPC_STANDBY &&
    !rxd_cfg_q[RXD_STYLE_BIT] && flags_q[0][FLAG_WAKE_BIT] |=> !rxd_out)
    else $error("rxd not held low on wake");
  rxd_pwron_a: assert property (mode_q == TPC_STANDBY &&
    flags_q[0][FLAG_PWRON_BIT] |=> !rxd_out)
    else $error("rxd high after power-up");
  sdo_role_a: assert property (spi_select_low_in &&
    !sdo_cfg_q[SDO_ROLE_BIT] |=> !sdo_oe_out)
    else $error("sdo driven without role");
  irq_pin_a: assert property (spi_select_low_in && irq_any &&
    sdo_cfg_q[SDO_ROLE_BIT] && mode_q != TPC_SLEEP
    |=> sdo_oe_out && !sdo_out) else $error("interrupt not shown");
  sdo_spi_a: assert property (!spi_select_low_in |=> sdo_oe_out &&
    sdo_out == $past(spi_bit)) else $error("sdo not spi data");
  irq_or_a: assert property (fault_set_in[8] && !masks_q[1][0]
    |=> irq_any) else $error("unmasked fault lost");
  tx_dominant_a: assert property (mode_q == TPC_NORMAL && !txd_in
    |=> can_dominant_out) else $error("txd low not dominant");
  mode_normal_a: assert property (wr_mode && wdata[2:0] == MODE_NORMAL &&
    !failsafe_event_in |=> mode_q == TPC_NORMAL)
    else $error("mode write ignored");

  sleep_wake_c: cover property (mode_q == TPC_SLEEP && wake_evt
    ##1 mode_q == TPC_STANDBY);
  fb_cycle_c: cover property ($rose(limp_on_q) ##[1:200] $fell(limp_on_q));
  irq_low_c: cover property (sdo_oe_out && !sdo_out && spi_select_low_in);
  fs_entry_c: cover property ($rose(mode_q == TPC_FAILSAFE));
endmodule

// ---- src/tpc_pkg.sv ----
// shared constants for the transceiver pin control block
package tpc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // register offsets
  localparam logic [6:0] ADDR_MODE = 7'h10;
  localparam logic [6:0] ADDR_WAKE_CFG = 7'h11;
  localparam logic [6:0] ADDR_RXD_CFG = 7'h12;
  localparam logic [6:0] ADDR_FS_CFG = 7'h13;
  localparam logic [6:0] ADDR_EN_CTRL = 7'h1a;
  localparam logic [6:0] ADDR_SDO_CFG = 7'h29;
  localparam logic [6:0] ADDR_GLOBAL = 7'h50;
  localparam logic [6:0] ADDR_FLAG0 = 7'h51;
  localparam logic [6:0] ADDR_MASK0 = 7'h5a;
  localparam int unsigned NUM_FLAG_REGS = 4;
  // field positions
  localparam int unsigned EN_DIS_BIT = 6;
  localparam int unsigned FB_SEL_BIT = 5;
  localparam int unsigned TRIG_SEL_LSB = 2;
  localparam int unsigned FB_RST_BIT = 1;
  localparam int unsigned RXD_STYLE_BIT = 2;
  localparam int unsigned SDO_ROLE_BIT = 0;
  localparam int unsigned FS_EN_BIT = 0;
  localparam int unsigned WAKE_FILT_BIT = 2;
  localparam int unsigned FLAG_WAKE_BIT = 7;
  localparam int unsigned FLAG_PWRON_BIT = 6;
  // reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] FLAG0_RST = 8'h40;
  // mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h7;
  localparam logic [2:0] MODE_LISTEN = 3'h6;
  localparam logic [2:0] MODE_STANDBY = 3'h4;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_FAILSAFE = 3'h3;
  // wake edge selection
  localparam logic [1:0] WAKE_BOTH = 2'h0;
  localparam logic [1:0] WAKE_RISE = 2'h1;
  localparam logic [1:0] WAKE_FALL = 2'h2;
  localparam logic [1:0] WAKE_PULSE = 2'h3;
  // release trigger counts
  localparam logic [1:0] TRIG_SEL_ONE = 2'h1;
  localparam logic [1:0] TRIGS_DEFAULT = 2'h3;
  localparam logic [1:0] TRIGS_ONE = 2'h1;
  // timing
  localparam int unsigned RXD_PULSE_NS = 2000;
  localparam int unsigned RXD_PULSE_CYC =
    (RXD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_FILT_NS = 1000;
  localparam int unsigned WAKE_FILT_CYC =
    (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    TPC_STANDBY, TPC_NORMAL, TPC_LISTEN, TPC_SLEEP, TPC_FAILSAFE
  } tpc_mode_e;
endpackage

// ---- src/tpc_spi_slave.sv ----
// spi register port, mode 0, 16-bit frames
`timescale 1ns/1ns
module tpc_spi_slave (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // spi pins
  input wire logic sclk_in,
  input wire logic spi_select_low_in,
  input wire logic sdi_in,
  // register side
  input wire logic [7:0] rdata_in,
  output logic sdo_out,
  output logic wr_out,
  output logic [6:0] addr_out,
  output logic [7:0] wdata_out
);
  logic sclk_q;
  logic [4:0] cnt_q;
  logic [6:0] sh_q;
  logic wflag_q;
  logic load_q;
  logic [7:0] tx_q;
  logic rise;
  logic fall;
  assign rise = sclk_in & ~sclk_q;
  assign fall = ~sclk_in & sclk_q;
  assign sdo_out = tx_q[7];
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_in;
    end
  end
  // shift in, address and write strobe
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 5'h00;
      sh_q <= 7'h00;
      wflag_q <= 1'b0;
      addr_out <= 7'h00;
      wdata_out <= 8'h00;
      wr_out <= 1'b0;
      load_q <= 1'b0;
    end else begin
      wr_out <= 1'b0;
      load_q <= 1'b0;
      if (spi_select_low_in) begin
        cnt_q <= 5'h00;
      end else if (rise && cnt_q != 5'h10) begin
        sh_q <= {sh_q[5:0], sdi_in};
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'h07) begin
          wflag_q <= sh_q[6];
          addr_out <= {sh_q[5:0], sdi_in};
          load_q <= 1'b1;
        end
        if (cnt_q == 5'h0f) begin
          wdata_out <= {sh_q[6:0], sdi_in};
          wr_out <= wflag_q;
        end
      end
    end
  end
  // read data out, msb first on falling edges
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_q <= 8'h00;
    end else if (spi_select_low_in) begin
      tx_q <= 8'h00;
    end else if (load_q) begin
      tx_q <= rdata_in;
    end else if (fall && cnt_q > 5'h08 && cnt_q < 5'h10) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end
  wr_select_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(wr_out) |-> $past(!spi_select_low_in))
    else $error("write taken with select high");
endmodule

// ---- src/tpc_wake_det.sv ----
// local wake pin detector: edges, filter, pulse width
`timescale 1ns/1ns
module tpc_wake_det
  import tpc_pkg::*;
#(
  parameter int unsigned FILT_CYC = WAKE_FILT_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // pin and control
  input wire logic wake_pin_in,
  input wire logic [7:0] cfg_in,
  input wire logic arm_in,
  output logic wake_out
);
  logic primed_q;
  logic filt_q;
  logic prev_q;
  logic [7:0] fcnt_q;
  logic [7:0] wcnt_q;
  logic lvl;
  logic rise;
  logic fall;
  logic pulse_ok;
  assign lvl = cfg_in[WAKE_FILT_BIT] ? filt_q : wake_pin_in;
  assign rise = primed_q & lvl & ~prev_q;
  assign fall = primed_q & ~lvl & prev_q;
  assign pulse_ok = wcnt_q >= {4'h0, cfg_in[7:4]} &&
    wcnt_q <= {3'h0, cfg_in[7:4], 1'b0};
  // glitch filter
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      primed_q <= 1'b0;
      filt_q <= 1'b0;
      prev_q <= 1'b0;
      fcnt_q <= 8'h00;
    end else begin
      primed_q <= 1'b1;
      prev_q <= primed_q ? lvl : wake_pin_in;
      if (!primed_q || wake_pin_in == filt_q) begin
        filt_q <= primed_q ? filt_q : wake_pin_in;
        fcnt_q <= 8'h00;
      end else if (fcnt_q >= 8'(FILT_CYC - 1)) begin
        filt_q <= wake_pin_in;
        fcnt_q <= 8'h00;
      end else begin
        fcnt_q <= fcnt_q + 8'h01;
      end
    end
  end
  // high pulse width and event select
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wcnt_q <= 8'h00;
      wake_out <= 1'b0;
    end else begin
      if (rise) begin
        wcnt_q <= 8'h01;
      end else if (lvl && wcnt_q != 8'hff) begin
        wcnt_q <= wcnt_q + 8'h01;
      end
      case (cfg_in[1:0])
        WAKE_BOTH: wake_out <= arm_in & (rise | fall);
        WAKE_RISE: wake_out <= arm_in & rise;
        WAKE_FALL: wake_out <= arm_in & fall;
        default: wake_out <= arm_in & fall & pulse_ok;
      endcase
    end
  end
  wake_both_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cfg_in[1:0] == WAKE_BOTH && arm_in && primed_q && lvl != prev_q
    |=> wake_out) else $error("wake edge missed");
  wake_rise_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cfg_in[1:0] == WAKE_RISE && fall |=> !wake_out)
    else $error("falling edge woke in rise mode");
endmodule

// ---- verification/tpc_host_model.sv ----
// host spi master model for the pin control bench
`timescale 1ns/1ns
module tpc_host_model (
  // clock
  input wire logic clk_in,
  // spi pins
  input wire logic sdo_pin_in,
  output logic sclk_out,
  output logic spi_select_low_out,
  output logic sdi_out
);
  initial begin
    sclk_out = 1'b0;
    spi_select_low_out = 1'b1;
    sdi_out = 1'b0;
  end
  // data line toggles while unselected
  always @(posedge clk_in) begin
    if (spi_select_low_out) sdi_out <= ~sdi_out;
  end
  ////////////////////////////////////////
  task automatic xfer(input logic [15:0] f, output logic [7:0] q);
    q = 8'h00;
    spi_select_low_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    for (int i = 15; i >= 0; i--) begin
      sdi_out <= f[i];
      repeat (4) @(posedge clk_in);
      if (i < 8) q[i] = sdo_pin_in;
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (2) @(posedge clk_in);
    spi_select_low_out <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask
endmodule

// ---- verification/tpc_pin_ctrl_tb_top.sv ----
// self-checking bench for the pin control block
`timescale 1ns/1ns
module tpc_pin_ctrl_tb_top;
  import tpc_pkg::*;
  logic clk_in, reset_n_in, txd_in, can_rx_in, wake_pin_in;
  logic wd_timeout_in, wd_good_trigger_in, wd_bad_trigger_in;
  logic failsafe_event_in;
  logic [31:0] fault_set_in;
  logic sclk, sel_n, sdi, sdo_out, sdo_oe_out, rxd_out, can_dom;
  logic reg_out, reg_oe;
  int err_total, compares;
  logic [1:0] wk [2] = '{WAKE_RISE, WAKE_FALL};
  logic [6:0] cfg_a [4] = '{ADDR_WAKE_CFG, ADDR_RXD_CFG, ADDR_EN_CTRL,
    ADDR_SDO_CFG};
  // shared pin has a pull-up
  wire logic sdo_pin = sdo_oe_out ? sdo_out : 1'b1;
  wire logic [7:0] regp = {6'h00, reg_out, reg_oe};
  tpc_pin_ctrl tpc_pin_ctrl_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .sclk_in(sclk), .spi_select_low_in(sel_n), .sdi_in(sdi),
    .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .txd_in(txd_in),
    .can_rx_in(can_rx_in), .rxd_out(rxd_out), .can_dominant_out(can_dom),
    .wake_pin_in(wake_pin_in), .regulator_enable_out(reg_out),
    .regulator_enable_oe_out(reg_oe), .wd_timeout_in(wd_timeout_in),
    .wd_good_trigger_in(wd_good_trigger_in),
    .wd_bad_trigger_in(wd_bad_trigger_in),
    .failsafe_event_in(failsafe_event_in), .fault_set_in(fault_set_in));
  tpc_host_model tpc_host_model_i (.clk_in(clk_in), .sdo_pin_in(sdo_pin),
    .sclk_out(sclk), .spi_select_low_out(sel_n), .sdi_out(sdi));
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    tpc_host_model_i.xfer({1'b1, a, d}, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    tpc_host_model_i.xfer({1'b0, a, 8'h00}, q);
    chk(q, e);
  endtask
  task automatic wd(input logic [2:0] p);
    {wd_timeout_in, wd_good_trigger_in, wd_bad_trigger_in} <= p;
    @(posedge clk_in) {wd_timeout_in, wd_good_trigger_in,
      wd_bad_trigger_in} <= 3'h0;
    cyc(3);
  endtask
  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    cyc(20000);
    err_total++;
    print_verdict();
  end
  initial begin
    err_total = 0;
    compares = 0;
    reset_n_in = 1'b0;
    {txd_in, can_rx_in, wake_pin_in} = 3'h6;
    {wd_timeout_in, wd_good_trigger_in, wd_bad_trigger_in} = 3'h0;
    failsafe_event_in = 1'b0;
    fault_set_in = 32'h0;
    cyc(8);
    reset_n_in <= 1'b1;
    cyc(3);
    chk(rxd_out, 8'h00);
    chk(regp, 8'h03);
    chk(sdo_oe_out, 8'h00);
    foreach (cfg_a[k]) rd(cfg_a[k], CFG_RST);
    rd(ADDR_GLOBAL, 8'h01);
    wr(7'h7f, 8'hff);
    rd(7'h7f, 8'h00);
    // interrupt role, mask, clear, set
    wr(ADDR_SDO_CFG, 8'h01);
    cyc(3);
    chk({sdo_oe_out, sdo_out}, 8'h02);
    rd(ADDR_SDO_CFG, 8'h01);
    wr(ADDR_MASK0, 8'h40);
    cyc(3);
    chk(sdo_pin, 8'h01);
    wr(ADDR_MASK0, 8'h00);
    wr(ADDR_FLAG0, FLAG0_RST);
    rd(ADDR_GLOBAL, 8'h00);
    fault_set_in <= 32'h100;
    @(posedge clk_in) fault_set_in <= 32'h0;
    cyc(3);
    chk(sdo_pin, 8'h00);
    rd(ADDR_GLOBAL, 8'h02);
    wr(7'h52, 8'h01);
    wr(ADDR_SDO_CFG, 8'h00);
    chk(sdo_oe_out, 8'h00);
    chk(rxd_out, 8'h01);
    // wake edges
    wake_pin_in <= 1'b1;
    cyc(5);
    chk(rxd_out, 8'h00);
    rd(ADDR_FLAG0, 8'h80);
    wr(ADDR_FLAG0, 8'h80);
    foreach (wk[k]) begin
      wr(ADDR_WAKE_CFG, {6'h00, wk[k]});
      repeat (2) begin
        wake_pin_in <= ~wake_pin_in;
        cyc(5);
        chk(rxd_out, !(wake_pin_in ^ (wk[k] == WAKE_FALL)));
        wr(ADDR_FLAG0, 8'h80);
      end
    end
    // filtered edges: glitch ignored, long level wakes
    wr(ADDR_WAKE_CFG, 8'h04);
    wake_pin_in <= 1'b0;
    cyc(3);
    wake_pin_in <= 1'b1;
    cyc(WAKE_FILT_CYC + 8);
    chk(rxd_out, 8'h01);
    wake_pin_in <= 1'b0;
    cyc(WAKE_FILT_CYC + 8);
    chk(rxd_out, 8'h00);
    wr(ADDR_FLAG0, 8'h80);
    // pulse mode, accepted width 2..4 cycles
    wr(ADDR_WAKE_CFG, 8'h23);
    wake_pin_in <= 1'b1;
    cyc(3);
    wake_pin_in <= 1'b0;
    cyc(5);
    chk(rxd_out, 8'h00);
    wr(ADDR_FLAG0, 8'h80);
    wake_pin_in <= 1'b1;
    cyc(8);
    wake_pin_in <= 1'b0;
    cyc(5);
    chk(rxd_out, 8'h01);
    wr(ADDR_WAKE_CFG, 8'h00);
    wr(ADDR_RXD_CFG, 8'h04);
    wake_pin_in <= ~wake_pin_in;
    cyc(10);
    chk(rxd_out, 8'h00);
    cyc(RXD_PULSE_CYC);
    chk(rxd_out, 8'h01);
    wr(ADDR_FLAG0, 8'h80);
    // normal and listen modes, can path
    wr(ADDR_MODE, {5'h00, MODE_NORMAL});
    rd(ADDR_MODE, 8'h07);
    for (int v = 0; v < 8; v++) begin
      if (v == 4) wr(ADDR_MODE, {5'h00, MODE_LISTEN});
      {can_rx_in, txd_in} <= v[1:0];
      cyc(3);
      chk({can_dom, rxd_out}, {~v[0] & ~v[2], v[1]});
    end
    rd(ADDR_MODE, 8'h06);
    // fallback output
    wr(ADDR_EN_CTRL, 8'h20);
    cyc(2);
    chk(regp, 8'h00);
    wd(3'h4);
    chk(regp, 8'h03);
    wd(3'h2);
    wd(3'h2);
    wd(3'h1);
    wd(3'h2);
    wd(3'h2);
    chk(regp, 8'h03);
    wd(3'h2);
    chk(regp, 8'h00);
    wr(ADDR_EN_CTRL, 8'h24);
    wd(3'h4);
    wd(3'h2);
    chk(regp, 8'h00);
    wd(3'h4);
    wr(ADDR_EN_CTRL, 8'h26);
    cyc(2);
    chk(regp, 8'h00);
    rd(ADDR_EN_CTRL, 8'h24);
    wr(ADDR_FS_CFG, 8'h01);
    failsafe_event_in <= 1'b1;
    @(posedge clk_in) failsafe_event_in <= 1'b0;
    cyc(3);
    chk(regp, 8'h03);
    rd(ADDR_MODE, 8'h03);
    // disable, sleep and wake
    wr(ADDR_EN_CTRL, 8'h40);
    cyc(2);
    chk(regp, 8'h00);
    wr(ADDR_EN_CTRL, 8'h00);
    wr(ADDR_MODE, {5'h00, MODE_SLEEP});
    cyc(2);
    chk(regp, 8'h00);
    wake_pin_in <= ~wake_pin_in;
    cyc(6);
    chk(regp, 8'h03);
    chk(rxd_out, 8'h00);
    rd(ADDR_MODE, 8'h04);
    print_verdict();
  end
endmodule
